// file: logic/vot_defines.vh
// Constants for the video output timing and test block: register offsets, field positions, reset values.
// Assumes a 32-bit AXI4-Lite slave; bit numbering follows the usual LSB-is-bit-0 convention.
`ifndef VOT_DEFINES_VH
`define VOT_DEFINES_VH
`define VOT_ADDR_W 12
`define VOT_OFS_HTOT 12'h15C
`define VOT_OFS_HSYNC 12'h160
`define VOT_OFS_VTOT 12'h164
`define VOT_OFS_VRET 12'h168
`define VOT_OFS_HRET 12'h16C
`define VOT_OFS_CBG 12'h170
`define VOT_OFS_CFG 12'h174
`define VOT_OFS_TVC 12'h178
`define VOT_OFS_TST 12'h17C
`define VOT_OFS_STAT 12'h180
`define VOT_OFS_SIG 12'h184
`define VOT_OFS_CNT 12'h188
`define VOT_HRET_LEN 5'h10
`define VOT_SEED 16'hFFFF
`define VOT_SIG_POLY 16'h1021
`define VOT_RESP_OKAY 2'b00
`define VOT_RESP_SLVERR 2'b10
// Masks of writable bits per register.
`define VOT_MASK_HPAIR 32'h07FF07FF
`define VOT_MASK_VPAIR 32'h03FF03FF
`define VOT_MASK_HRET 32'h000007FF
`define VOT_MASK_COLOR 32'h00FFFFFF
`define VOT_MASK_TVC 32'h0FFFFFFF
`define VOT_MASK_TST 32'h001F7FFF
// Field positions in the test control register, counted from the least significant bit.
`define VOT_TST_ARM 20
`define VOT_TST_PRESET 19
`define VOT_TST_CHECK 18
`define VOT_TST_DIR 14
`define VOT_TST_TEST 4
`define VOT_TST_TVV 3
`define VOT_TST_TVH 2
`define VOT_TST_BAR 1
`define VOT_TST_GRAY 0
`define VOT_STRM_MAX 3'h4
`define VOT_CSEL_DISP 6'h0D
`define VOT_CSEL_TV 6'h0E
`endif

// file: logic/vot_raster.v
// Display raster counters, sync, retrace and display enable generation.
// Assumes a synchronous, active-low reset and one clock at pixel rate.
`timescale 1ns/1ns
`default_nettype none
`include "vot_defines.vh"
module vot_raster (
  input wire aclk,
  input wire aresetn,
  input wire [10:0] h_total,
  input wire [10:0] h_disp_end,
  input wire [10:0] hsync_start,
  input wire [10:0] hsync_end,
  input wire [10:0] hret_start,
  input wire [9:0] v_total,
  input wire [9:0] v_disp_end,
  input wire [9:0] vret_start,
  input wire [9:0] vret_end,
  output reg [10:0] h_count,
  output reg [9:0] v_count,
  output reg hsync,
  output reg hretrace,
  output reg vretrace,
  output reg disp_en
);
  reg [4:0] hret_cnt;
  wire line_end = (h_count >= h_total);
  wire [10:0] next_h = line_end ? 11'h000 : h_count + 11'h001;
  wire [9:0] next_v = line_end ? ((v_count >= v_total) ? 10'h000 : v_count + 10'h001) : v_count;
  always @(posedge aclk) begin
    if (!aresetn) begin
      h_count <= 11'h000;
      v_count <= 10'h000;
      hsync <= 1'b0;
      hretrace <= 1'b0;
      hret_cnt <= 5'h00;
      vretrace <= 1'b0;
      disp_en <= 1'b0;
    end else begin
      h_count <= next_h;
      v_count <= next_v;
      if (next_h == hsync_start) begin
        hsync <= 1'b1;
      end else if (next_h == hsync_end) begin
        hsync <= 1'b0;
      end
      // A running pulse is never restarted, so its width stays 16 clocks whatever the registers hold.
      if (hretrace) begin
        if (hret_cnt != 5'h00) begin
          hret_cnt <= hret_cnt - 5'h01;
        end else begin
          hretrace <= 1'b0;
        end
      end else if (next_h == hret_start) begin
        hretrace <= 1'b1;
        hret_cnt <= `VOT_HRET_LEN - 5'h01;
      end
      if (next_v == vret_start) begin
        vretrace <= 1'b1;
      end else if (next_v == vret_end) begin
        vretrace <= 1'b0;
      end
      disp_en <= (next_h < h_disp_end) && (next_v < v_disp_end);
    end
  end
endmodule // vot_raster
`default_nettype wire

// file: logic/vot_top.v
// Video output timing and test block with its AXI4-Lite register file.
// Assumes one pixel-rate clock; stream counters and state machines live elsewhere and arrive as inputs.
`timescale 1ns/1ns
`default_nettype none
`include "vot_defines.vh"
module vot_top (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] pix_red,
  input wire [7:0] pix_green,
  input wire [7:0] pix_blue,
  input wire [7:0] tv_composite,
  input wire [7:0] tv_luma,
  input wire [7:0] tv_chroma,
  input wire [29:0] ext_counter,
  input wire [4:0] stream_state0,
  input wire [4:0] stream_state1,
  input wire [4:0] stream_state2,
  input wire [4:0] stream_state3,
  input wire [4:0] stream_state4,
  input wire [9:0] tv_h_count,
  input wire [9:0] tv_v_count,
  output reg hsync,
  output reg hretrace,
  output reg vretrace,
  output reg disp_en,
  output reg [23:0] cursor_bg,
  output reg [23:0] cursor_fg,
  output reg [3:0] test_output_select,
  output reg tv_encoder_on,
  output reg svideo_on,
  output reg [1:0] tv_system,
  output reg [7:0] tv_raster_width,
  output reg [7:0] tv_raster_height,
  output reg tv_h_test_on,
  output reg tv_v_test_on,
  output reg video_pin_direction,
  output reg test_mode,
  output reg color_bar_on,
  output reg gray_level_on,
  output reg [7:0] out_red,
  output reg [7:0] out_green,
  output reg [7:0] out_blue
);
  reg [31:0] r_htot, r_hsync, r_vtot, r_vret, r_hret, r_cbg, r_cfg, r_tvc, r_tst;
  reg [15:0] signature;
  reg sig_busy;
  reg arm_q;
  reg aw_held, w_held;
  reg [11:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire [10:0] h_count;
  wire [9:0] v_count;
  wire r_hsync_w, r_hret_w, r_vret_w, r_den_w;

  // Register fields are numbered here from bit 0 at the least significant end.
  // Byte-lane merge limited to the register's writable bits.
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    input [31:0] mask;
    reg [31:0] lanes;
    begin
      lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
      merge = (old & ~lanes) | (data & lanes);
    end
  endfunction

  function mapped;
    input [11:0] a;
    begin
      mapped = (a[1:0] == 2'b00) && (a >= `VOT_OFS_HTOT) && (a <= `VOT_OFS_CNT);
    end
  endfunction

  // Cursor colours leave with blue in the top byte and red in the bottom byte.
  function [23:0] color_swap;
    input [31:0] c;
    begin
      color_swap = {c[7:0], c[15:8], c[23:16]};
    end
  endfunction

  vot_raster u_raster (
    .aclk(aclk),
    .aresetn(aresetn),
    .h_total(r_htot[26:16]),
    .h_disp_end(r_htot[10:0]),
    .hsync_start(r_hsync[26:16]),
    .hsync_end(r_hsync[10:0]),
    .hret_start(r_hret[10:0]),
    .v_total(r_vtot[25:16]),
    .v_disp_end(r_vtot[9:0]),
    .vret_start(r_vret[25:16]),
    .vret_end(r_vret[9:0]),
    .h_count(h_count),
    .v_count(v_count),
    .hsync(r_hsync_w),
    .hretrace(r_hret_w),
    .vretrace(r_vret_w),
    .disp_en(r_den_w)
  );

  // Write channel: address and data are taken independently, the response follows both.
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `VOT_RESP_OKAY;
      r_htot <= 32'h00000000;
      r_hsync <= 32'h00000000;
      r_vtot <= 32'h00000000;
      r_vret <= 32'h00000000;
      r_hret <= 32'h00000000;
      r_cbg <= 32'h00000000;
      r_cfg <= 32'h00000000;
      r_tvc <= 32'h00000000;
      r_tst <= 32'h00000000;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      s_axi_wready <= !w_held && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? `VOT_RESP_OKAY : `VOT_RESP_SLVERR;
        case (aw_addr)
          `VOT_OFS_HTOT: r_htot <= merge(r_htot, w_data, w_strb, `VOT_MASK_HPAIR);
          `VOT_OFS_HSYNC: r_hsync <= merge(r_hsync, w_data, w_strb, `VOT_MASK_HPAIR);
          `VOT_OFS_VTOT: r_vtot <= merge(r_vtot, w_data, w_strb, `VOT_MASK_VPAIR);
          `VOT_OFS_VRET: r_vret <= merge(r_vret, w_data, w_strb, `VOT_MASK_VPAIR);
          `VOT_OFS_HRET: r_hret <= merge(r_hret, w_data, w_strb, `VOT_MASK_HRET);
          `VOT_OFS_CBG: r_cbg <= merge(r_cbg, w_data, w_strb, `VOT_MASK_COLOR);
          `VOT_OFS_CFG: r_cfg <= merge(r_cfg, w_data, w_strb, `VOT_MASK_COLOR);
          `VOT_OFS_TVC: r_tvc <= merge(r_tvc, w_data, w_strb, `VOT_MASK_TVC);
          `VOT_OFS_TST: r_tst <= merge(r_tst, w_data, w_strb, `VOT_MASK_TST);
          default: ;
        endcase
      end
    end
  end

  // Counter observation; only the display raster count is held here, the TV raster count and the others come from outside.
  reg [29:0] count_view;
  reg [4:0] state_view;
  always @* begin
    case (r_tst[13:8])
      `VOT_CSEL_DISP: count_view = {9'h000, h_count, v_count};
      `VOT_CSEL_TV: count_view = {10'h000, tv_h_count, tv_v_count};
      default: count_view = ext_counter;
    endcase
    case (r_tst[7:5])
      3'h0: state_view = stream_state0;
      3'h1: state_view = stream_state1;
      3'h2: state_view = stream_state2;
      3'h3: state_view = stream_state3;
      3'h4: state_view = stream_state4;
      default: state_view = 5'h00;
    endcase
  end

  reg [31:0] rd_word;
  always @* begin
    case (s_axi_araddr)
      `VOT_OFS_HTOT: rd_word = r_htot;
      `VOT_OFS_HSYNC: rd_word = r_hsync;
      `VOT_OFS_VTOT: rd_word = r_vtot;
      `VOT_OFS_VRET: rd_word = r_vret;
      `VOT_OFS_HRET: rd_word = r_hret;
      `VOT_OFS_CBG: rd_word = r_cbg;
      `VOT_OFS_CFG: rd_word = r_cfg;
      `VOT_OFS_TVC: rd_word = r_tvc;
      `VOT_OFS_TST: rd_word = r_tst;
      `VOT_OFS_STAT: rd_word = {22'h000000, disp_en, sig_busy, vretrace, hretrace, hsync, state_view};
      `VOT_OFS_SIG: rd_word = {16'h0000, signature};
      `VOT_OFS_CNT: rd_word = r_tst[`VOT_TST_TEST] ? {2'b00, count_view} : 32'h00000000;
      default: rd_word = 32'h00000000;
    endcase
  end

  // Read data is captured at the address handshake, so a write still in flight shows only on a later read.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `VOT_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= mapped(s_axi_araddr) ? `VOT_RESP_OKAY : `VOT_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Signature analyser: one CRC step per displayed pixel while armed.
  // Busy stays up until the arm bit is cleared, so software decides how many fields are folded in.
  // The seed is loaded on reset and on the arming edge unless the preset bit is set; short of reset, disarming and arming again with it clear is the only restart.
  reg [7:0] sig_in;
  always @* begin
    case (r_tst[17:16])
      2'b01: sig_in = r_tvc[19] ? tv_composite : pix_red;
      2'b10: sig_in = r_tvc[19] ? tv_luma : pix_green;
      2'b11: sig_in = r_tvc[19] ? tv_chroma : pix_blue;
      default: sig_in = 8'h00;
    endcase
  end
  wire [15:0] sig_shift = {signature[14:0], 1'b0} ^ (signature[15] ? `VOT_SIG_POLY : 16'h0000);
  always @(posedge aclk) begin
    if (!aresetn) begin
      signature <= `VOT_SEED;
      sig_busy <= 1'b0;
      arm_q <= 1'b0;
    end else begin
      arm_q <= r_tst[`VOT_TST_ARM];
      if (!r_tst[`VOT_TST_ARM]) begin
        sig_busy <= 1'b0;
      end else if (!arm_q) begin
        sig_busy <= 1'b1;
        if (!r_tst[`VOT_TST_PRESET]) begin
          signature <= `VOT_SEED;
        end
      end
      if (sig_busy && r_den_w) begin
        signature <= sig_shift ^ {8'h00, sig_in};
      end
    end
  end

  // Test patterns: colour bars change every 128 pixels (h_count bits 9:7), gray ramps with the pixel count.
  wire [2:0] bar = h_count[9:7];
  always @(posedge aclk) begin
    if (!aresetn) begin
      hsync <= 1'b0;
      hretrace <= 1'b0;
      vretrace <= 1'b0;
      disp_en <= 1'b0;
      cursor_bg <= 24'h000000;
      cursor_fg <= 24'h000000;
      test_output_select <= 4'h0;
      tv_encoder_on <= 1'b0;
      svideo_on <= 1'b0;
      tv_system <= 2'b00;
      tv_raster_width <= 8'h00;
      tv_raster_height <= 8'h00;
      tv_h_test_on <= 1'b0;
      tv_v_test_on <= 1'b0;
      video_pin_direction <= 1'b0;
      test_mode <= 1'b0;
      color_bar_on <= 1'b0;
      gray_level_on <= 1'b0;
      out_red <= 8'h00;
      out_green <= 8'h00;
      out_blue <= 8'h00;
    end else begin
      hsync <= r_hsync_w;
      hretrace <= r_hret_w;
      vretrace <= r_vret_w;
      disp_en <= r_den_w;
      cursor_bg <= color_swap(r_cbg);
      cursor_fg <= color_swap(r_cfg);
      if (r_tvc[24]) begin
        test_output_select <= {r_tvc[24], r_tvc[25], r_tvc[26], r_tvc[27]};
      end else begin
        test_output_select <= 4'h0;
      end
      tv_encoder_on <= r_tvc[19];
      svideo_on <= r_tvc[19] & r_tvc[18];
      tv_system <= r_tvc[17:16];
      tv_h_test_on <= r_tst[`VOT_TST_TVH];
      tv_v_test_on <= r_tst[`VOT_TST_TVV];
      tv_raster_width <= r_tst[`VOT_TST_TVH] ? r_tvc[15:8] : 8'h00;
      tv_raster_height <= r_tst[`VOT_TST_TVV] ? r_tvc[7:0] : 8'h00;
      video_pin_direction <= r_tst[`VOT_TST_DIR];
      test_mode <= r_tst[`VOT_TST_TEST];
      color_bar_on <= r_tst[`VOT_TST_BAR];
      gray_level_on <= r_tst[`VOT_TST_GRAY];
      if (!r_den_w) begin
        out_red <= 8'h00;
        out_green <= 8'h00;
        out_blue <= 8'h00;
      end else if (r_tst[`VOT_TST_BAR]) begin
        out_red <= {8{~bar[1]}};
        out_green <= {8{~bar[2]}};
        out_blue <= {8{~bar[0]}};
      end else if (r_tst[`VOT_TST_GRAY]) begin
        out_red <= h_count[7:0];
        out_green <= h_count[7:0];
        out_blue <= h_count[7:0];
      end else begin
        out_red <= pix_red;
        out_green <= pix_green;
        out_blue <= pix_blue;
      end
    end
  end
endmodule // vot_top
`default_nettype wire

// file: sim/vot_top_chk.sv
// Port-level checks on the video timing block.
// Assumes it is bound into vot_top and sees its ports as they are.
`timescale 1ns/1ns
`default_nettype none
module vot_top_chk (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire hretrace,
  input wire [3:0] test_output_select,
  input wire tv_encoder_on,
  input wire svideo_on,
  input wire tv_h_test_on,
  input wire tv_v_test_on,
  input wire [7:0] tv_raster_width,
  input wire [7:0] tv_raster_height
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Counts the current retrace run; it saturates so a stuck pulse cannot wrap back to a legal width.
  logic [5:0] hret_run;
  always @(posedge aclk) begin
    if (!aresetn || !hretrace) begin
      hret_run <= 6'h00;
    end else if (hret_run != 6'h3F) begin
      hret_run <= hret_run + 6'h01;
    end
  end
  hret_len_a: assert property ($fell(hretrace) |-> hret_run == 6'h10)
    else $error("horizontal retrace width is not 16 clocks");
  tv_width_a: assert property (!tv_h_test_on |-> tv_raster_width == 8'h00)
    else $error("raster width used outside horizontal test");
  tv_height_a: assert property (!tv_v_test_on |-> tv_raster_height == 8'h00)
    else $error("raster height used outside vertical test");
  svideo_mode_a: assert property (svideo_on |-> tv_encoder_on)
    else $error("s-video on while encoder off");
  test_sel_a: assert property (!test_output_select[3] |-> test_output_select == 4'h0)
    else $error("test output selected without enable");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read answer late");
  cover property ($fell(hretrace));
  cover property (svideo_on);
  cover property (tv_h_test_on && tv_raster_width != 8'h00);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule // vot_top_chk
bind vot_top vot_top_chk u_chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .hretrace, .test_output_select, .tv_encoder_on,
  .svideo_on, .tv_h_test_on, .tv_v_test_on, .tv_raster_width, .tv_raster_height);
`default_nettype wire

// file: sim/vot_display.sv
// Behavioural display that measures the sync and blanking it receives.
// Assumes active-high sync, retrace and display enable on one pixel clock.
`timescale 1ns/1ns
`default_nettype none
module vot_display (
  input wire aclk,
  input wire hsync,
  input wire vretrace,
  input wire disp_en,
  output var int hs_high,
  output var int hs_period,
  output var int de_high,
  output var int vr_lines,
  output var int frame_lines,
  output var int frames
);
  int n_hs, n_per, n_de, n_vr, n_fr;
  logic hs_q, vr_q, de_q;
  // A real monitor locks on edges only, so every figure is latched at an edge.
  always @(posedge aclk) begin
    hs_q <= hsync;
    vr_q <= vretrace;
    de_q <= disp_en;
    n_per <= n_per + 1;
    n_hs <= hsync ? n_hs + 1 : 0;
    n_de <= disp_en ? n_de + 1 : 0;
    if (!hsync && hs_q) hs_high <= n_hs;
    if (!disp_en && de_q) de_high <= n_de;
    if (hsync && !hs_q) begin
      hs_period <= n_per;
      n_per <= 1;
      n_fr <= n_fr + 1;
      if (vretrace) n_vr <= n_vr + 1;
    end
    if (vretrace && !vr_q) begin
      frame_lines <= n_fr;
      n_fr <= 0;
      frames <= frames + 1;
    end
    if (!vretrace && vr_q) begin
      vr_lines <= n_vr;
      n_vr <= 0;
    end
  end
endmodule // vot_display
`default_nettype wire

// file: sim/test_video_output_timing_and_test.sv
// Self-checking bench for the video timing block with a display model.
// Assumes the block's defines header is on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "vot_defines.vh"
module test_video_output_timing_and_test;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic [29:0] stim = 30'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, tv_system;
  wire [31:0] s_axi_rdata;
  wire hsync, hretrace, vretrace, disp_en, tv_encoder_on, svideo_on, tv_h_test_on, tv_v_test_on;
  wire video_pin_direction, test_mode, color_bar_on, gray_level_on;
  wire [23:0] cursor_bg, cursor_fg;
  wire [3:0] test_output_select;
  wire [7:0] tv_raster_width, tv_raster_height, out_red, out_green, out_blue;
  int hs_high, hs_period, de_high, vr_lines, frame_lines, frames, error_cnt, checks_done, cyc;
  // Upstream video inputs follow a free-running count so no data path sits on a constant.
  vot_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pix_red(stim[7:0]),
    .pix_green(stim[8:1]), .pix_blue(stim[9:2]), .tv_composite(stim[10:3]), .tv_luma(stim[11:4]),
    .tv_chroma(stim[12:5]), .ext_counter(stim), .stream_state0(stim[4:0]), .stream_state1(stim[5:1]),
    .stream_state2(stim[6:2]), .stream_state3(stim[7:3]), .stream_state4(stim[8:4]), .tv_h_count(stim[9:0]),
    .tv_v_count(stim[19:10]), .hsync, .hretrace, .vretrace, .disp_en, .cursor_bg, .cursor_fg,
    .test_output_select, .tv_encoder_on, .svideo_on, .tv_system, .tv_raster_width, .tv_raster_height,
    .tv_h_test_on, .tv_v_test_on, .video_pin_direction, .test_mode, .color_bar_on, .gray_level_on,
    .out_red, .out_green, .out_blue);
  vot_display u_disp (.aclk, .hsync, .vretrace, .disp_en, .hs_high, .hs_period, .de_high, .vr_lines,
    .frame_lines, .frames);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic end_sim();
    if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge aclk) begin
    stim <= stim + 30'h1;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_done, w_done;
    {aw_done, w_done} = 2'b00;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1 && !aw_done) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !w_done) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic t_regs();
    logic [11:0] ofs [9] = '{`VOT_OFS_HTOT, `VOT_OFS_HSYNC, `VOT_OFS_VTOT, `VOT_OFS_VRET, `VOT_OFS_HRET,
      `VOT_OFS_CBG, `VOT_OFS_CFG, `VOT_OFS_TVC, `VOT_OFS_TST};
    logic [31:0] msk [9] = '{`VOT_MASK_HPAIR, `VOT_MASK_HPAIR, `VOT_MASK_VPAIR, `VOT_MASK_VPAIR,
      `VOT_MASK_HRET, `VOT_MASK_COLOR, `VOT_MASK_COLOR, `VOT_MASK_TVC, `VOT_MASK_TST};
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 9; i++) begin
      rd(ofs[i], d, r);
      chk("reset value", d, 32'h0);
      wr(ofs[i], 32'hFFFFFFFF, r);
      chk("write resp", {30'h0, r}, {30'h0, `VOT_RESP_OKAY});
      rd(ofs[i], d, r);
      chk("ones readback", d, msk[i]);
      wr(ofs[i], 32'h0, r);
    end
    rd(12'h200, d, r);
    chk("unmapped resp", {30'h0, r}, {30'h0, `VOT_RESP_SLVERR});
    chk("unmapped data", d, 32'h0);
    wr(12'h15E, 32'h1, r);
    chk("unaligned resp", {30'h0, r}, {30'h0, `VOT_RESP_SLVERR});
    wr(`VOT_OFS_CBG, 32'h00123456, r);
    wr(`VOT_OFS_CFG, 32'h00ABCDEF, r);
    repeat (2) @(posedge aclk);
    chk("cursor bg", {8'h0, cursor_bg}, 32'h00563412);
    chk("cursor fg", {8'h0, cursor_fg}, 32'h00EFCDAB);
  endtask
  task automatic t_raster();
    logic [1:0] r;
    int f;
    wr(`VOT_OFS_HTOT, 32'h00630050, r);
    wr(`VOT_OFS_HSYNC, 32'h0054005C, r);
    wr(`VOT_OFS_VTOT, 32'h00090006, r);
    wr(`VOT_OFS_VRET, 32'h00070009, r);
    wr(`VOT_OFS_HRET, 32'h0000000A, r);
    f = frames;
    while (frames < f + 3) @(posedge aclk);
    chk("line period", hs_period, 32'h64);
    chk("displayed pixels", de_high, 32'h50);
    chk("sync width", hs_high, 32'h8);
    chk("frame lines", frame_lines, 32'hA);
    chk("retrace lines", vr_lines, 32'h2);
  endtask
  task automatic t_tv();
    logic [1:0] r;
    int b [6] = '{`VOT_TST_DIR, `VOT_TST_TEST, `VOT_TST_TVV, `VOT_TST_TVH, `VOT_TST_BAR, `VOT_TST_GRAY};
    wr(`VOT_OFS_TVC, 32'h0B000000, r);
    repeat (2) @(posedge aclk);
    chk("test select", {28'h0, test_output_select}, 32'hD);
    wr(`VOT_OFS_TVC, 32'h0E000000, r);
    repeat (2) @(posedge aclk);
    chk("select off", {28'h0, test_output_select}, 32'h0);
    for (int i = 0; i < 16; i++) begin
      wr(`VOT_OFS_TVC, {12'h0, i[3:0], 16'hABCD}, r);
      repeat (2) @(posedge aclk);
      chk("encoder on", tv_encoder_on, i[3]);
      chk("svideo", svideo_on, i[3] & i[2]);
      chk("tv system", tv_system, i[1:0]);
      chk("width off", tv_raster_width, 32'h0);
    end
    for (int k = 0; k < 6; k++) begin
      wr(`VOT_OFS_TST, 32'h1 << b[k], r);
      repeat (2) @(posedge aclk);
      chk("test bits", {gray_level_on, color_bar_on, tv_h_test_on, tv_v_test_on, test_mode,
        video_pin_direction}, 32'h1 << k);
      chk("test width", tv_raster_width, b[k] == `VOT_TST_TVH ? 32'hAB : 32'h0);
      chk("test height", tv_raster_height, b[k] == `VOT_TST_TVV ? 32'hCD : 32'h0);
    end
  endtask
  // Gray ramp first, then colour bars; the first two pixels of a line are compared.
  task automatic t_pattern();
    logic [1:0] r;
    for (int k = 0; k < 2; k++) begin
      wr(`VOT_OFS_TST, 32'h1 << (k == 0 ? `VOT_TST_GRAY : `VOT_TST_BAR), r);
      do @(posedge aclk); while (disp_en !== 1'b0);
      do @(posedge aclk); while (disp_en !== 1'b1);
      chk("first pixel", {8'h0, out_red, out_green, out_blue}, k == 0 ? 32'h0 : 32'hFFFFFF);
      @(posedge aclk);
      chk("second pixel", {8'h0, out_red, out_green, out_blue}, k == 0 ? 32'h010101 : 32'hFFFFFF);
    end
  endtask
  task automatic t_sig();
    logic [31:0] d;
    logic [1:0] r;
    wr(`VOT_OFS_TST, 32'h1 << `VOT_TST_ARM, r);
    rd(`VOT_OFS_STAT, d, r);
    chk("analyser busy", {31'h0, d[8]}, 32'h1);
    wr(`VOT_OFS_TST, 32'h0, r);
    rd(`VOT_OFS_STAT, d, r);
    chk("analyser idle", {31'h0, d[8]}, 32'h0);
    rd(`VOT_OFS_CNT, d, r);
    chk("counter view off", d, 32'h0);
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_raster();
    t_tv();
    t_pattern();
    t_sig();
    end_sim();
  end
endmodule // test_video_output_timing_and_test
`default_nettype wire
